// ==== rtl/gpio_pkg.sv ====
/*
  gpio_pkg: register indexes, reset values, per-pin feature masks and
  interrupt group layout for the six-port pin controller.
  assumes: pin i of the flat 48-bit vectors is port i/8, bit i%8, port a lowest.
*/
package gpio_pkg;
  localparam int NUM_PORTS  = 6;
  localparam int PORT_W     = 8;
  localparam int NUM_PINS   = NUM_PORTS * PORT_W;
  localparam int NUM_GROUPS = 4;

  // register indexes; byte address is four times the index
  localparam logic [7:0] PORT_A_DATA_LATCH_IDX = 8'h00;
  localparam logic [7:0] PORT_A_DIRECTION_IDX  = 8'h01;
  localparam logic [7:0] PORT_A_OPTION_IDX     = 8'h02;
  localparam logic [7:0] PORT_B_DATA_LATCH_IDX = 8'h03;
  localparam logic [7:0] PORT_B_DIRECTION_IDX  = 8'h04;
  localparam logic [7:0] PORT_B_OPTION_IDX     = 8'h05;
  localparam logic [7:0] PORT_C_DATA_LATCH_IDX = 8'h06;
  localparam logic [7:0] PORT_C_DIRECTION_IDX  = 8'h07;
  localparam logic [7:0] PORT_C_OPTION_IDX     = 8'h08;
  localparam logic [7:0] PORT_D_DATA_LATCH_IDX = 8'h09;
  localparam logic [7:0] PORT_D_DIRECTION_IDX  = 8'h0a;
  localparam logic [7:0] PORT_D_OPTION_IDX     = 8'h0b;
  localparam logic [7:0] PORT_E_DATA_LATCH_IDX = 8'h0c;
  localparam logic [7:0] PORT_E_DIRECTION_IDX  = 8'h0d;
  localparam logic [7:0] PORT_E_OPTION_IDX     = 8'h0e;
  localparam logic [7:0] PORT_F_DATA_LATCH_IDX = 8'h0f;
  localparam logic [7:0] PORT_F_DIRECTION_IDX  = 8'h10;
  localparam logic [7:0] PORT_F_OPTION_IDX     = 8'h11;
  localparam logic [7:0] IRQ_STATUS_IDX        = 8'h12;
  localparam logic [7:0] IRQ_MASK_IDX          = 8'h13;
  localparam logic [7:0] EXT_INT_SENSE_IDX     = 8'h14;

  localparam logic [7:0] DATA_IDX [NUM_PORTS] = '{PORT_A_DATA_LATCH_IDX, PORT_B_DATA_LATCH_IDX,
    PORT_C_DATA_LATCH_IDX, PORT_D_DATA_LATCH_IDX, PORT_E_DATA_LATCH_IDX, PORT_F_DATA_LATCH_IDX};
  localparam logic [7:0] DIR_IDX [NUM_PORTS] = '{PORT_A_DIRECTION_IDX, PORT_B_DIRECTION_IDX,
    PORT_C_DIRECTION_IDX, PORT_D_DIRECTION_IDX, PORT_E_DIRECTION_IDX, PORT_F_DIRECTION_IDX};
  localparam logic [7:0] OPT_IDX [NUM_PORTS] = '{PORT_A_OPTION_IDX, PORT_B_OPTION_IDX,
    PORT_C_OPTION_IDX, PORT_D_OPTION_IDX, PORT_E_OPTION_IDX, PORT_F_OPTION_IDX};

  localparam logic [7:0] PORT_REG_RESET = 8'h00;
  localparam logic [3:0] IRQ_RESET      = 4'h0;
  localparam logic [7:0] SENSE_RESET    = 8'h00;

  // per-pin features, {f,e,d,c,b,a}
  localparam logic [47:0] INT_CAP_MASK     = 48'h0700_0000_ff0f;
  localparam logic [47:0] INT_PULLUP_MASK  = 48'h0300_0000_7707;
  localparam logic [47:0] TRUE_OD_MASK     = 48'h0000_0000_00c0;
  localparam logic [47:0] PULLUP_ALWAYS    = 48'h0004_0000_0000;

  // interrupt vector groups: a3:0, f2:0, b3:0, b7:4
  localparam logic [47:0] GROUP_MASK [NUM_GROUPS] = '{48'h0000_0000_000f,
    48'h0700_0000_0000, 48'h0000_0000_0f00, 48'h0000_0000_f000};

  // sensitivity codes, two bits per group
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
endpackage : gpio_pkg

// ==== rtl/gpio_pin_if.sv ====
/*
  gpio_pin_if: flat per-pin bundle between the register block and the
  pin mode decoder.
  assumes: one bit per pin, width set by the instantiating module.
*/
`timescale 1ns/1ps
interface gpio_pin_if #(parameter int N = 48);
  logic [N-1:0] data;
  logic [N-1:0] dir;
  logic [N-1:0] opt;
  logic [N-1:0] pad_in;
  logic [N-1:0] af_out_en;
  logic [N-1:0] af_out;
  logic [N-1:0] read_val;
  logic [N-1:0] af_in;
  logic [N-1:0] pad_out;
  logic [N-1:0] pad_oe_n;
  logic [N-1:0] pull_en;
  logic [N-1:0] int_cand;

  modport ctrl (output data, dir, opt, pad_in, af_out_en, af_out,
                input  read_val, af_in, pad_out, pad_oe_n, pull_en, int_cand);
  modport pins (input  data, dir, opt, pad_in, af_out_en, af_out,
                output read_val, af_in, pad_out, pad_oe_n, pull_en, int_cand);
endinterface : gpio_pin_if

// ==== rtl/pin_mode_decode.sv ====
/*
  pin_mode_decode: turns direction, option and latch bits into pad drive,
  pull-up, readback, peripheral input and interrupt candidacy, per pin.
  assumes: purely combinational; registers live in the instantiating module.
*/
`timescale 1ns/1ps
module pin_mode_decode
  import gpio_pkg::*;
(
  gpio_pin_if.pins pio
);
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      logic drive_en;
      logic drive_val;
      logic push_pull;

      // a peripheral output takes priority over the latch
      assign drive_en  = pio.af_out_en[i] | pio.dir[i];
      assign drive_val = pio.af_out_en[i] ? pio.af_out[i] : pio.data[i];
      // true open-drain pads never push high, whatever the option bit says
      assign push_pull = pio.opt[i] & ~TRUE_OD_MASK[i];

      // a one in open-drain mode releases the pad
      assign pio.pad_out[i]  = drive_en & drive_val & push_pull;
      assign pio.pad_oe_n[i] = ~(drive_en & (push_pull | ~drive_val));

      // pull-up: input with option set, except floating-interrupt and true od pins
      assign pio.pull_en[i] = PULLUP_ALWAYS[i] |
                              (~drive_en & pio.opt[i] & ~TRUE_OD_MASK[i] &
                               (~INT_CAP_MASK[i] | INT_PULLUP_MASK[i]));

      // readback: latch when output, peripheral output, else pad level
      assign pio.read_val[i] = pio.dir[i] ? pio.data[i] :
                               (pio.af_out_en[i] ? pio.af_out[i] : pio.pad_in[i]);
      // peripheral input sees the latch while the pin is an output
      assign pio.af_in[i] = pio.dir[i] ? pio.data[i] : pio.pad_in[i];
      assign pio.int_cand[i] = INT_CAP_MASK[i] & ~pio.dir[i] & pio.opt[i];
    end
  endgenerate
endmodule : pin_mode_decode

// ==== rtl/gpio_port_mode_control.sv ====
/*
  gpio_port_mode_control: six 8-bit i/o ports behind an apb slave, with
  external interrupt groups, vector pending latches and a status/mask irq.
  assumes: pad inputs synchronous to pclk; apb master per the amba spec;
  the pad ring resolves pad_out/pad_oe_n/pull_up_en into real levels.
*/
`timescale 1ns/1ps
// Operation
// - input pin with peripheral output enabled reads back the peripheral output.
// - output pin with peripheral input gets the data latch value.
// - low-power states leave ports alone; pending pin interrupts wake the device while the cpu mask is clear.
// - interrupt only in interrupt-input mode and with cpu mask clear; the status/mask irq output ignores cpu_int_masked.
// - standard pins: 00 float, 01 pull-up, 10 open drain, 11 push-pull.
// - interrupt pins: dir 0 opt 1 is interrupt input, pull-up on listed pins.
// - port a pins 6,7: direction only; output is true open drain.
// - port e pin 2 always pulled up; output mode chosen by option.
// - eighteen port registers at consecutive indexes, all reset to zero.
// - input pin: data read returns pad level; writes touch only the latch.
// - output pin driven from latch; data read returns the latch.
// - open drain releases on one; push-pull drives high; zero drives low.
// - group events pass sensitivity then OR; pending clears on vector fetch.
module gpio_port_mode_control
  import gpio_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int WIDTH = PORT_W
)(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NUM_PINS-1:0]   pad_in,
  output logic      [NUM_PINS-1:0]   pad_out,
  output logic      [NUM_PINS-1:0]   pad_oe_n,
  output logic      [NUM_PINS-1:0]   pull_up_en,
  input  wire logic [NUM_PINS-1:0]   af_out_en,
  input  wire logic [NUM_PINS-1:0]   af_out,
  output logic      [NUM_PINS-1:0]   af_in,
  input  wire logic                  cpu_int_masked,
  input  wire logic [NUM_GROUPS-1:0] vector_fetch,
  output logic      [NUM_GROUPS-1:0] ext_irq_req,
  output logic                       wake_req,
  output logic                       irq
);
  // the register map and masks are laid out for exactly six 8-bit ports
  generate
    if (PORTS != NUM_PORTS || WIDTH != PORT_W) begin : g_bad_cfg
      $error("gpio_port_mode_control: only six 8-bit ports supported");
    end
  endgenerate

  gpio_pin_if #(.N(NUM_PINS)) pio ();

  logic [7:0]            data_q [NUM_PORTS];
  logic [7:0]            dir_q  [NUM_PORTS];
  logic [7:0]            opt_q  [NUM_PORTS];
  logic [NUM_GROUPS-1:0] status_q;
  logic [NUM_GROUPS-1:0] mask_q;
  logic [7:0]            sense_q;
  logic [NUM_GROUPS-1:0] pend_q;
  logic [NUM_PINS-1:0]   prev_q;
  logic [31:0]           prdata_q;
  logic [31:0]           rd_d;
  logic [7:0]            reg_idx;
  logic                  mapped;
  logic                  wr_en;
  logic [NUM_GROUPS-1:0] grp_hit;
  logic [NUM_GROUPS-1:0] sense_chg;

  // apb decode: zero wait states, so the access phase always completes
  assign reg_idx = {2'b00, paddr[7:2]};
  assign mapped  = (paddr[1:0] == 2'b00) && (reg_idx <= EXT_INT_SENSE_IDX);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite & mapped;
  assign prdata  = prdata_q;

  // flatten the per-port registers toward the pin decoder
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign pio.data[gp*PORT_W +: PORT_W] = data_q[gp];
      assign pio.dir[gp*PORT_W +: PORT_W]  = dir_q[gp];
      assign pio.opt[gp*PORT_W +: PORT_W]  = opt_q[gp];
    end
  endgenerate
  assign pio.pad_in    = pad_in;
  assign pio.af_out_en = af_out_en;
  assign pio.af_out    = af_out;

  pin_mode_decode u_decode (
    .pio (pio.pins)
  );

  assign pad_out    = pio.pad_out;
  assign pad_oe_n   = pio.pad_oe_n;
  assign pull_up_en = pio.pull_en;
  assign af_in      = pio.af_in;

  // port registers; a latch write never disturbs an input pin's pad
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        data_q[p] <= PORT_REG_RESET;
        dir_q[p]  <= PORT_REG_RESET;
        opt_q[p]  <= PORT_REG_RESET;
      end
    end else if (wr_en) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (reg_idx == DATA_IDX[p]) begin
          data_q[p] <= pwdata[7:0];
        end
        if (reg_idx == DIR_IDX[p]) begin
          dir_q[p] <= pwdata[7:0];
        end
        // true open-drain pins have no option bit; it stays zero
        if (reg_idx == OPT_IDX[p]) begin
          opt_q[p] <= pwdata[7:0] & ~TRUE_OD_MASK[p*PORT_W +: PORT_W];
        end
      end
    end
  end

  // read mux; unmapped and reserved bits read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (reg_idx == DATA_IDX[p]) begin
        rd_d[7:0] = pio.read_val[p*PORT_W +: PORT_W];
      end
      if (reg_idx == DIR_IDX[p]) begin
        rd_d[7:0] = dir_q[p];
      end
      if (reg_idx == OPT_IDX[p]) begin
        rd_d[7:0] = opt_q[p];
      end
    end
    if (reg_idx == IRQ_STATUS_IDX) begin
      rd_d[NUM_GROUPS-1:0] = status_q;
    end
    if (reg_idx == IRQ_MASK_IDX) begin
      rd_d[NUM_GROUPS-1:0] = mask_q;
    end
    if (reg_idx == EXT_INT_SENSE_IDX) begin
      rd_d[7:0] = sense_q;
    end
    if (!mapped) begin
      rd_d = 32'h0000_0000;
    end
  end

  // read data is captured in the setup phase so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_d;
    end
  end

  // previous pad level for edge detection; a high pad right after reset
  // looks like a rising edge, so software should arm interrupts later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= {NUM_PINS{1'b0}};
    end else begin
      prev_q <= pad_in;
    end
  end

  // per group: apply its sensitivity to every candidate pin, then OR
  always_comb begin
    logic [NUM_PINS-1:0] det;
    det = {NUM_PINS{1'b0}};
    for (int g = 0; g < NUM_GROUPS; g++) begin
      case (sense_q[2*g +: 2])
        SENSE_LOW:  det = ~pad_in;
        SENSE_RISE: det = pad_in & ~prev_q;
        SENSE_FALL: det = ~pad_in & prev_q;
        SENSE_BOTH: det = pad_in ^ prev_q;
        default:    det = {NUM_PINS{1'b0}};
      endcase
      grp_hit[g] = |(det & pio.int_cand & GROUP_MASK[g]);
    end
  end

  // a sensitivity write that changes a group's code drops its pending request
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      sense_chg[g] = wr_en && (reg_idx == EXT_INT_SENSE_IDX) &&
                     (pwdata[2*g +: 2] != sense_q[2*g +: 2]);
    end
  end

  // sensitivity register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_q <= SENSE_RESET;
    end else if (wr_en && reg_idx == EXT_INT_SENSE_IDX) begin
      sense_q <= pwdata[7:0];
    end
  end

  // hidden pending latch per vector; a new event beats the fetch clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= IRQ_RESET;
    end else begin
      pend_q <= grp_hit | (pend_q & ~(vector_fetch | sense_chg));
    end
  end

  // requests reach the cpu only while its interrupt mask is clear
  assign ext_irq_req = pend_q & {NUM_GROUPS{~cpu_int_masked}};
  // port state is never touched by low power; any live request wakes
  assign wake_req = |ext_irq_req;

  // software-visible sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= IRQ_RESET;
    end else begin
      if (wr_en && reg_idx == IRQ_STATUS_IDX) begin
        status_q <= (status_q & ~pwdata[NUM_GROUPS-1:0]) | grp_hit;
      end else begin
        status_q <= status_q | grp_hit;
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= IRQ_RESET;
    end else if (wr_en && reg_idx == IRQ_MASK_IDX) begin
      mask_q <= pwdata[NUM_GROUPS-1:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // port f group armed: some pin of it is an interrupt input
  logic grp1_armed;
  assign grp1_armed = |(pio.int_cand & GROUP_MASK[1]);

  a_af_readback: assert property (
    (~pio.dir & af_out_en & (pio.read_val ^ af_out)) == '0)
    else $error("input pin with peripheral output reads wrong value");

  a_af_input_latch: assert property (
    (pio.dir & (af_in ^ pio.data)) == '0)
    else $error("peripheral input on output pin differs from latch");

  a_wake_pending: assert property (
    (pend_q != '0 && !cpu_int_masked) |-> wake_req)
    else $error("pending unmasked request does not wake");

  a_irq_gate_mask: assert property (
    cpu_int_masked |-> ext_irq_req == '0)
    else $error("interrupt request ignores cpu mask");

  a_irq_pass_open: assert property (
    !cpu_int_masked |-> ext_irq_req == pend_q)
    else $error("pending request held back while cpu mask is clear");

  a_hit_needs_mode: assert property (
    $rose(pend_q[1]) |-> $past(grp1_armed))
    else $error("pending set without interrupt-input pin");

  a_std_pullup: assert property (
    (~af_out_en[20] |-> pull_up_en[20] == (~pio.dir[20] & pio.opt[20])))
    else $error("standard pin pull-up decode wrong");

  a_float_int_pin: assert property (
    (pio.dir[3] == 1'b0 && pio.opt[3]) |-> !pull_up_en[3] && pio.int_cand[3])
    else $error("floating interrupt pin decode wrong");

  a_true_od_pins: assert property (
    opt_q[0][7:6] == 2'b00 && pad_out[7:6] == 2'b00)
    else $error("true open-drain pin drives high");

  a_pe2_pullup: assert property (
    pull_up_en[34])
    else $error("port e pin two pull-up dropped");

  a_latch_write: assert property (
    wr_en && reg_idx == PORT_C_DATA_LATCH_IDX |=> data_q[2] == $past(pwdata[7:0]))
    else $error("port c latch write lost");

  a_input_read: assert property (
    psel && !penable && !pwrite && paddr == 8'h18 && !pio.dir[16] && !af_out_en[16]
    |=> prdata[0] == $past(pad_in[16]))
    else $error("input pin read does not return pad level");

  a_output_read: assert property (
    psel && !penable && !pwrite && paddr == 8'h24 && pio.dir[24]
    |=> prdata[0] == $past(pio.data[24]))
    else $error("output pin read does not return the latch");

  a_od_release: assert property (
    (pio.dir[24] && !af_out_en[24] && pio.data[24] && !pio.opt[24]) |-> pad_oe_n[24])
    else $error("open-drain one still drives the pad");

  a_zero_sinks: assert property (
    (pio.dir[24] && !af_out_en[24] && !pio.data[24]) |-> !pad_oe_n[24] && !pad_out[24])
    else $error("output zero does not pull the pad low");

  a_pp_drive: assert property (
    (pio.dir[40] && !af_out_en[40] && pio.opt[40]) |-> !pad_oe_n[40] && pad_out[40] == pio.data[40])
    else $error("push-pull pin does not follow the latch");

  a_fetch_clears: assert property (
    vector_fetch[2] && !grp_hit[2] |=> !pend_q[2])
    else $error("vector fetch does not clear pending");

  a_pend_hold: assert property (
    pend_q[3] && !vector_fetch[3] && !sense_chg[3] |=> pend_q[3])
    else $error("pending request lost without fetch");

  a_sense_drop: assert property (
    sense_chg[1] && !grp_hit[1] |=> !pend_q[1])
    else $error("sensitivity change does not drop pending");

  // cover points for the main scenarios
  c_wake_event: cover property (!cpu_int_masked && $rose(wake_req));
  c_af_readback: cover property (af_out_en[9] && !pio.dir[9]);
  c_status_irq: cover property ($rose(irq));
  c_fetch_clear: cover property (vector_fetch[0] && pend_q[0]);
  c_held_by_mask: cover property (cpu_int_masked && pend_q != '0);
endmodule : gpio_port_mode_control

// ==== bench/pad_world.sv ====
/*
  pad_world: external circuitry at the 48 pads; resolves each pad level.
  assumes: pad outputs come from the pin controller, and the bench picks
  which released pads it drives and with which value.
*/
`timescale 1ns/1ps
module pad_world
  import gpio_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic [NUM_PINS-1:0] pad_out,
  input  wire logic [NUM_PINS-1:0] pad_oe_n,
  input  wire logic [NUM_PINS-1:0] pull_up_en,
  input  wire logic [NUM_PINS-1:0] ext_want,
  input  wire logic [NUM_PINS-1:0] ext_val,
  output logic      [NUM_PINS-1:0] pad_level
);
  logic [NUM_PINS-1:0] churn_q = '0;

  // a floating pad wanders every cycle so a stale level never reads as valid
  always_ff @(posedge pclk) begin
    churn_q <= ~churn_q;
  end

  // device drive first; the outside only drives pads that the device released
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad_oe_n[i] === 1'b0) begin
        pad_level[i] = pad_out[i];
      end else if (ext_want[i]) begin
        pad_level[i] = ext_val[i];
      end else if (pull_up_en[i] === 1'b1) begin
        pad_level[i] = 1'b1;
      end else begin
        pad_level[i] = churn_q[i]; // open-drain high left floating
      end
    end
  end
endmodule : pad_world

// ==== bench/tb.sv ====
/*
  tb: self-checking bench for the six-port pin controller.
  assumes: apb slave at pclk, pad_world model at the pads, fixed seed.
*/
`timescale 1ns/1ps
module tb
  import gpio_pkg::*;
;
  logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                  cpu_int_masked = 1'b0, pready, pslverr, wake_req, irq, err;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0000_0000, prdata, rd;
  logic [NUM_PINS-1:0]   pad_in, pad_out, pad_oe_n, pull_up_en, af_in;
  logic [NUM_PINS-1:0]   af_out_en = '0, af_out = '0, ext_val = '1, dir_v = '0, opt_v = '0, dat_v = '0;
  logic [NUM_GROUPS-1:0] vector_fetch = '0, ext_irq_req;
  int                    err_total = 0, cmp_count = 0;

  always #20 pclk = ~pclk;

  gpio_port_mode_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pull_up_en(pull_up_en), .af_out_en(af_out_en), .af_out(af_out), .af_in(af_in),
    .cpu_int_masked(cpu_int_masked), .vector_fetch(vector_fetch), .ext_irq_req(ext_irq_req),
    .wake_req(wake_req), .irq(irq));

  pad_world i_pads (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
    .ext_want(~dir_v & ~af_out_en), .ext_val(ext_val), .pad_level(pad_in));

  // pull-up on option-set inputs, never on plain interrupt or true open-drain pins
  function automatic logic [47:0] exp_pull(input logic [47:0] d, o);
    return PULLUP_ALWAYS | (~d & o & ~TRUE_OD_MASK & ~(INT_CAP_MASK & ~INT_PULLUP_MASK));
  endfunction : exp_pull

  // released when input, or open drain holding a one
  function automatic logic [47:0] exp_oen(input logic [47:0] d, o, v);
    return ~d | (~(o & ~TRUE_OD_MASK) & v);
  endfunction : exp_oen

  function automatic logic [47:0] rnd48();
    return 48'({$urandom(), $urandom()});
  endfunction : rnd48

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  // one transfer: setup, then access until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state budget here; only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string nm);
    apb(1'b0, {idx[5:0], 2'b00}, 32'h0000_0000);
    chk(nm, {56'h0, e}, rd);
  endtask : rdc

  task automatic wr_all();
    for (int p = 0; p < NUM_PORTS; p++) begin
      apb(1'b1, {DATA_IDX[p][5:0], 2'b00}, {24'h0, dat_v[p*8 +: 8]}); // latch before direction
      apb(1'b1, {DIR_IDX[p][5:0], 2'b00}, {24'h0, dir_v[p*8 +: 8]});
      apb(1'b1, {OPT_IDX[p][5:0], 2'b00}, {24'h0, opt_v[p*8 +: 8]});
    end
  endtask : wr_all

  task automatic check_regs();
    logic [47:0] om, rv, m;
    om = opt_v & ~TRUE_OD_MASK;
    rv = (dir_v & dat_v) | (~dir_v & af_out_en & af_out) | (~dir_v & ~af_out_en & ext_val);
    m  = ~af_out_en;
    for (int p = 0; p < NUM_PORTS; p++) begin
      rdc(DATA_IDX[p], rv[p*8 +: 8], "data");
      rdc(DIR_IDX[p], dir_v[p*8 +: 8], "direction");
      rdc(OPT_IDX[p], om[p*8 +: 8], "option");
    end
    chk("pull_up_en", exp_pull(dir_v, opt_v) & m, pull_up_en & m);
    chk("pad_oe_n", exp_oen(dir_v, opt_v, dat_v) & m, pad_oe_n & m);
    chk("pad_out", dat_v & ~exp_oen(dir_v, opt_v, dat_v) & m, pad_out & ~pad_oe_n & m);
    chk("af_in", dat_v & dir_v, af_in & dir_v);
  endtask : check_regs

  // all pads to one level, then let the edge detectors see it
  task automatic step(input logic v);
    @(posedge pclk);
    ext_val <= {NUM_PINS{v}};
    repeat (3) @(posedge pclk);
  endtask : step

  task automatic fetch_all();
    @(posedge pclk);
    vector_fetch <= 4'hf;
    @(posedge pclk);
    vector_fetch <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask : fetch_all

  initial begin
    #(40 * 20000);
    err_total++;
    summarize();
  end

  initial begin
    void'($urandom(15687));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_regs();
    apb(1'b0, 8'h54, 32'h0000_0000);
    chk("unmapped error", 64'h1, err);
    chk("unmapped data", 64'h0, rd);
    apb(1'b1, 8'h05, 32'h0000_00ff);
    chk("unaligned error", 64'h1, err);
    // random modes; peripheral outputs only on non-interrupt inputs
    repeat (6) begin
      @(posedge pclk);
      dir_v   <= rnd48();
      opt_v   <= rnd48();
      dat_v   <= rnd48();
      ext_val <= rnd48();
      af_out  <= rnd48();
      @(posedge pclk);
      af_out_en <= rnd48() & ~dir_v & ~(opt_v & INT_CAP_MASK);
      wr_all();
      repeat (3) @(posedge pclk);
      check_regs();
    end
    // interrupts: group g gets sensitivity code g (low, rise, fall, both)
    @(posedge pclk);
    af_out_en <= '0;
    dir_v     <= '0;
    opt_v     <= '0;
    ext_val   <= '1;
    wr_all();
    repeat (2) @(posedge pclk);
    // every pin now a floating input with the pull-up off, except the always-pulled port e pin 2
    chk("analog float pull", PULLUP_ALWAYS, pull_up_en);
    chk("analog float oe", {NUM_PINS{1'b1}}, pad_oe_n);
    apb(1'b1, 8'h50, 32'h0000_00e4);
    apb(1'b1, 8'h4c, 32'h0000_000f);
    apb(1'b1, 8'h48, 32'h0000_000f);
    fetch_all();
    step(1'b0);
    step(1'b1);
    rdc(IRQ_STATUS_IDX, 8'h00, "status no int mode");
    // floating input straight to interrupt input is a safe transition
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b1, 8'h14, 32'h0000_0011);
    apb(1'b1, 8'h44, 32'h0000_0001);
    step(1'b0);
    rdc(IRQ_STATUS_IDX, 8'h0d, "status low");
    chk("ext_irq_req low", 64'hd, ext_irq_req);
    chk("wake_req", 64'h1, wake_req);
    chk("irq", 64'h1, irq);
    step(1'b1);
    rdc(IRQ_STATUS_IDX, 8'h0f, "status high");
    chk("ext_irq_req high", 64'hf, ext_irq_req);
    fetch_all();
    chk("ext_irq_req fetched", 64'h0, ext_irq_req);
    apb(1'b1, 8'h4c, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("irq masked", 64'h0, irq);
    apb(1'b1, 8'h4c, 32'h0000_000f);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 64'h1, irq);
    apb(1'b1, 8'h48, 32'h0000_000f);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 64'h0, irq);
    rdc(IRQ_STATUS_IDX, 8'h00, "status cleared");
    @(posedge pclk);
    cpu_int_masked <= 1'b1;
    step(1'b0);
    chk("ext_irq_req cpu masked", 64'h0, ext_irq_req);
    chk("wake_req cpu masked", 64'h0, wake_req);
    @(posedge pclk);
    cpu_int_masked <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("ext_irq_req cpu open", 64'hd, ext_irq_req);
    chk("wake_req cpu open", 64'h1, wake_req);
    summarize();
  end
endmodule : tb
